//--- parallel_io_regs.svh
`ifndef PARALLEL_IO_REGS_SVH
`define PARALLEL_IO_REGS_SVH

// pin count of one port
`define PARALLEL_IO_WIDTH 16
// register byte offsets on the apb window
`define DIR_OFFSET 12'h000
`define PIN_OFFSET 12'h004
`define LAT_OFFSET 12'h008
`define ANA_OFFSET 12'h00c
// reset values
`define DIR_RESET 16'hffff
`define LAT_RESET 16'h0000
`define ANA_RESET 16'h0000
// implemented pin mask and input-only pin mask defaults
`define IMPL_MASK_DEFAULT 16'hffff
`define INONLY_MASK_DEFAULT 16'h0000

`endif

//--- parallel_io_pkg.sv
package parallel_io_pkg;
    // apb slave phases
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SETUP = 3'b010,
        ST_ACCESS = 3'b100
    } apb_state_e;
    // one word of port data
    typedef logic [15:0] port_word_t;
endpackage

//--- pin_slice.sv
`timescale 1ns/1ps
// one pin: output ownership multiplexers and input read path
module pin_slice (
    // configuration
    input wire logic implemented_in,
    input wire logic input_only_in,
    input wire logic analog_in,
    // port side
    input wire logic dir_in,
    input wire logic lat_in,
    // peripheral side
    input wire logic periph_drive_in,
    input wire logic periph_data_in,
    // pad side
    input wire logic pad_in,
    output logic pad_out,
    output logic pad_oe_n_out,
    output logic pin_read_out
);
    logic port_oe_n;
    logic periph_owns;

    always_comb begin
        // unimplemented bits never drive, and a set direction bit means input
        port_oe_n = !implemented_in || dir_in;
        // input-only sharers have no output to compete with
        periph_owns = periph_drive_in && !input_only_in && implemented_in;
        // peripheral wins both data and enable when it is driving
        if (periph_owns) begin
            pad_out = periph_data_in;
            pad_oe_n_out = 1'b0;
        end else begin
            pad_out = lat_in;
            pad_oe_n_out = port_oe_n;
        end
        // analog pins and absent bits read low; pad still readable under peripheral
        pin_read_out = implemented_in && !analog_in && pad_in;
    end
endmodule

//--- shared_parallel_io_port.sv
`timescale 1ns/1ps
`include "parallel_io_regs.svh"

// Summary of operation
// - direction, latch and pin register per pin
// - direction one means input, no drive
// - reset sets every implemented direction bit to input
// - latch reads stored value, write updates
// - pin reads sampled pads, write hits latch
// - unimplemented bits disabled and read zero
// - driving peripheral disables port driver, readable
// - idle peripheral lets port drive pin
// - peripheral beats port on data and enable
// - input-only sharer pins stay dedicated port
// - analog pins read low via pin register
module shared_parallel_io_port
    import parallel_io_pkg::*;
#(
    parameter logic [15:0] IMPL_MASK = `IMPL_MASK_DEFAULT,
    parameter logic [15:0] INONLY_MASK = `INONLY_MASK_DEFAULT
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic arst_n_in,
    // apb slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // peripherals sharing the pins
    input wire logic [15:0] periph_drive_in,
    input wire logic [15:0] periph_data_in,
    // pad cells
    input wire logic [15:0] pad_in,
    output logic [15:0] pad_out,
    output logic [15:0] pad_oe_n_out
);
    port_word_t dir_r, dir_nxt; // direction, one = input
    port_word_t lat_r, lat_nxt; // output latch
    port_word_t ana_r, ana_nxt; // analog-input select
    port_word_t pin_r, pin_nxt; // sampled pin levels
    port_word_t pin_read; // per-pin read value
    logic [31:0] rdata_r, rdata_nxt; // read data register
    logic slverr_r, slverr_nxt; // error flag for the access
    apb_state_e state_r, state_nxt; // bus phase tracker
    logic wr_en; // write takes effect this edge
    logic hit_dir, hit_pin, hit_lat, hit_ana, hit_any;
    port_word_t wmask; // byte-lane mask of the write
    port_word_t wdata; // write data clipped to port width

    // one slice per pin
    genvar g;
    generate
        for (g = 0; g < `PARALLEL_IO_WIDTH; g++) begin : gen_pin
            pin_slice u_slice (
                .implemented_in(IMPL_MASK[g]),
                .input_only_in(INONLY_MASK[g]),
                .analog_in(ana_r[g]),
                .dir_in(dir_r[g]),
                .lat_in(lat_r[g]),
                .periph_drive_in(periph_drive_in[g]),
                .periph_data_in(periph_data_in[g]),
                .pad_in(pad_in[g]),
                .pad_out(pad_out[g]),
                .pad_oe_n_out(pad_oe_n_out[g]),
                .pin_read_out(pin_read[g])
            );
        end
    endgenerate

    // address decode; unmapped offsets answer with pslverr
    always_comb begin
        hit_dir = (paddr_in == `DIR_OFFSET);
        hit_pin = (paddr_in == `PIN_OFFSET);
        hit_lat = (paddr_in == `LAT_OFFSET);
        hit_ana = (paddr_in == `ANA_OFFSET);
        hit_any = hit_dir || hit_pin || hit_lat || hit_ana;
        wmask = {{8{pstrb_in[1]}}, {8{pstrb_in[0]}}};
        wdata = pwdata_in[15:0];
        // zero wait states: a write lands at the access-phase edge
        wr_en = psel_in && penable_in && pwrite_in;
    end

    // bus phase next state, informative for debug and checking
    always_comb begin
        state_nxt = ST_IDLE;
        case (state_r)
            ST_IDLE: begin
                state_nxt = psel_in ? ST_SETUP : ST_IDLE;
            end
            ST_SETUP: begin
                state_nxt = ST_ACCESS;
            end
            ST_ACCESS: begin
                state_nxt = psel_in ? ST_SETUP : ST_IDLE;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // register file next values
    always_comb begin
        dir_nxt = dir_r;
        lat_nxt = lat_r;
        ana_nxt = ana_r;
        // pins sampled every cycle, so readback trails a write by a cycle
        pin_nxt = pin_read;
        if (wr_en && hit_dir) begin
            dir_nxt = ((dir_r & ~wmask) | (wdata & wmask)) & IMPL_MASK;
        end
        // a write to the latch or to the pin register both update the latch
        if (wr_en && (hit_lat || hit_pin)) begin
            lat_nxt = ((lat_r & ~wmask) | (wdata & wmask)) & IMPL_MASK;
        end
        if (wr_en && hit_ana) begin
            ana_nxt = ((ana_r & ~wmask) | (wdata & wmask)) & IMPL_MASK;
        end
    end

    // read data and error, captured in the setup phase so it stands in access
    always_comb begin
        rdata_nxt = rdata_r;
        slverr_nxt = slverr_r;
        if (psel_in && !penable_in) begin
            slverr_nxt = !hit_any;
            if (hit_dir) begin
                rdata_nxt = {16'h0000, dir_r};
            end else if (hit_pin) begin
                rdata_nxt = {16'h0000, pin_r};
            end else if (hit_lat) begin
                rdata_nxt = {16'h0000, lat_r};
            end else if (hit_ana) begin
                rdata_nxt = {16'h0000, ana_r};
            end else begin
                rdata_nxt = 32'h0000_0000;
            end
        end
    end

    // state registers; every implemented direction bit resets to input
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            // absent bits already read zero in the very first cycle after reset
            dir_r <= `DIR_RESET & IMPL_MASK;
            lat_r <= `LAT_RESET;
            ana_r <= `ANA_RESET;
            pin_r <= 16'h0000;
            rdata_r <= 32'h0000_0000;
            slverr_r <= 1'b0;
            state_r <= ST_IDLE;
        end else begin
            // masked again so an implemented-subset parameter still holds
            dir_r <= dir_nxt & IMPL_MASK;
            lat_r <= lat_nxt;
            ana_r <= ana_nxt;
            pin_r <= pin_nxt;
            rdata_r <= rdata_nxt;
            slverr_r <= slverr_nxt;
            state_r <= state_nxt;
        end
    end

    // bus answer: always ready, error only inside the access phase
    always_comb begin
        prdata_out = rdata_r;
        pready_out = 1'b1;
        pslverr_out = psel_in && penable_in && slverr_r;
    end

    // write to direction reaches the register next cycle, masked
    a_dir_write: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (wr_en && hit_dir && pstrb_in == 4'hf) |=> dir_r == ($past(wdata) & IMPL_MASK))
        else $error("direction write not stored");

    // pin register write lands in the latch
    a_pin_to_lat: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (wr_en && hit_pin && pstrb_in == 4'hf) |=> lat_r == ($past(wdata) & IMPL_MASK))
        else $error("pin register write missed latch");

    // input direction never drives unless a peripheral owns the pin
    a_input_no_drive: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (pad_oe_n_out & ~(periph_drive_in & ~INONLY_MASK & IMPL_MASK)) ==
        ((dir_r | ~IMPL_MASK) & ~(periph_drive_in & ~INONLY_MASK & IMPL_MASK)))
        else $error("input pin driven by port");

    // owned output pin shows the latch
    a_latch_drive: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        ((pad_out ^ lat_r) & ~dir_r & ~(periph_drive_in & ~INONLY_MASK)) == 16'h0000)
        else $error("output pin not latch value");

    // peripheral owns data and enable
    a_periph_owns: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (((pad_out ^ periph_data_in) | pad_oe_n_out)
        & periph_drive_in & ~INONLY_MASK & IMPL_MASK) == 16'h0000)
        else $error("peripheral lost pad ownership");

    // unimplemented and analog bits read zero through the pin register
    a_pin_zero: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        ##1 (pin_r & ($past(ana_r) | ~IMPL_MASK)) == 16'h0000)
        else $error("analog or absent pin reads high");

    // latch read returns the latch one cycle after setup
    sequence s_lat_setup;
        psel_in && !penable_in && !pwrite_in && hit_lat;
    endsequence
    a_lat_read: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        s_lat_setup |=> prdata_out == {16'h0000, $past(lat_r)})
        else $error("latch read wrong");

    // all pins input right after reset
    a_reset_input: assert property (@(posedge clk_in)
        $rose(arst_n_in) |-> dir_r == (`DIR_RESET & IMPL_MASK))
        else $error("direction not input after reset");

    // bus phases as this slave sees them; the answer checks share them
    sequence s_setup_phase;
        psel_in && !penable_in;
    endsequence
    sequence s_access_phase;
        psel_in && penable_in;
    endsequence
    // setups on an unmapped offset and on a register, for the error checks
    sequence s_bad_setup;
        psel_in && !penable_in && !hit_any;
    endsequence
    sequence s_good_setup;
        psel_in && !penable_in && hit_any;
    endsequence

    // the phase tracker is one-hot, so a stray code shows up at once
    a_phase_onehot: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        $onehot(state_r))
        else $error("bus phase tracker not one-hot");

    // every setup is tracked into the next cycle
    a_phase_tracked: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        s_setup_phase |=> state_r == ST_SETUP)
        else $error("setup phase not tracked");

    // a setup followed by its access leaves the tracker in access
    a_access_tracked: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        s_setup_phase ##1 s_access_phase |=> state_r == ST_ACCESS)
        else $error("access phase not tracked");

    // unmapped offsets answer with an error in the access phase
    a_error_unmapped: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        s_bad_setup ##1 s_access_phase |-> pslverr_out)
        else $error("unmapped access without error");

    // mapped offsets never raise an error
    a_error_mapped: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        s_good_setup ##1 s_access_phase |-> !pslverr_out)
        else $error("mapped access flagged as error");

    // a write to an unmapped offset leaves the direction, latch and analog registers alone
    a_stray_write: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (wr_en && !hit_any) |=> $stable(dir_r) && $stable(lat_r) && $stable(ana_r))
        else $error("unmapped write changed a register");

    // the low byte lane alone leaves the upper latch bits untouched
    a_lane_low: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (wr_en && hit_lat && pstrb_in[1:0] == 2'b01) |=>
        lat_r == {$past(lat_r[15:8]), $past(wdata[7:0]) & IMPL_MASK[7:0]})
        else $error("byte lane write wrong");

    // absent bits never hold a direction, latch or analog value
    a_absent_bits: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        ((dir_r | lat_r | ana_r) & ~IMPL_MASK) == 16'h0000)
        else $error("absent bit holds a value");

    // absent bits never drive their pad
    a_absent_quiet: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (~pad_oe_n_out & ~IMPL_MASK) == 16'h0000)
        else $error("absent bit drives its pad");

    // input-only sharers keep plain port data and enable whatever the peripheral does
    a_inonly_port: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        (((pad_out ^ lat_r) | (pad_oe_n_out ^ (dir_r | ~IMPL_MASK)))
        & INONLY_MASK) == 16'h0000)
        else $error("input-only pin taken by peripheral");

    // an implemented, non-analog pin under a driving peripheral still reads its pad a cycle later
    a_periph_readable: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        ##1 ((pin_r ^ $past(pad_in)) & $past(periph_drive_in & IMPL_MASK & ~ana_r))
        == 16'h0000)
        else $error("pin under peripheral not readable");

    // a direction read returns the register, absent bits as zero
    sequence s_dir_setup;
        psel_in && !penable_in && !pwrite_in && hit_dir;
    endsequence
    a_dir_read: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        s_dir_setup |=> prdata_out == {16'h0000, $past(dir_r)})
        else $error("direction read wrong");

    // a pin register read returns the sampled pins, not the latch
    sequence s_pin_setup;
        psel_in && !penable_in && !pwrite_in && hit_pin;
    endsequence
    a_pin_read: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        s_pin_setup |=> prdata_out == {16'h0000, $past(pin_r)})
        else $error("pin register read wrong");
endmodule

//--- pad_model.sv
`timescale 1ns/1ps
// far side of the pads: a driven pad follows the port, an idle pad shows the outside level
module pad_model (
    // pad cells
    input wire logic [15:0] pad_out_in,
    input wire logic [15:0] pad_oe_n_in,
    // level that outside circuits put on undriven pins
    input wire logic [15:0] ext_level_in,
    output logic [15:0] pad_in_out
);
    // per bit wire resolution; the low enable means the chip owns the wire
    always_comb begin
        pad_in_out = (pad_out_in & ~pad_oe_n_in) | (ext_level_in & pad_oe_n_in);
    end
endmodule

//--- shared_parallel_io_port_test.sv
`timescale 1ns/1ps
`include "parallel_io_regs.svh"
module shared_parallel_io_port_test;
    import parallel_io_pkg::*;
    // bus and pin signals
    logic clk_in, arst_n_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out, err;
    logic [11:0] paddr_in;
    logic [31:0] pwdata_in, prdata_out, rd;
    logic [3:0] pstrb_in;
    port_word_t periph_drive_in, periph_data_in, pad_in, pad_out, pad_oe_n_out, ext_level;
    int error_cnt, num_checks;
    // bit 15 left out, bit 0 shared with an input-only function
    shared_parallel_io_port #(.IMPL_MASK(16'h7fff), .INONLY_MASK(16'h0001)) uut (
        .clk_in(clk_in), .arst_n_in(arst_n_in),
        .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
        .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pstrb_in(pstrb_in),
        .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
        .periph_drive_in(periph_drive_in), .periph_data_in(periph_data_in),
        .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n_out(pad_oe_n_out));
    pad_model pads (.pad_out_in(pad_out), .pad_oe_n_in(pad_oe_n_out),
        .ext_level_in(ext_level), .pad_in_out(pad_in));
    // clock source
    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end
    // one compare for every kind of result, all widened to a word
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one apb transfer; two idle cycles after it give the pin sampler time to settle
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= wd;
        @(posedge clk_in);
        penable_in <= 1'b1;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready_out !== 1'b1 && n < 50);
        if (n >= 50) error_cnt++;
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        repeat (2) @(posedge clk_in);
    endtask
    // read and compare in one call
    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    // single end of run
    task automatic print_verdict();
        if (error_cnt == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // hang guard, far beyond the hundred or so cycles the sequence needs
    initial begin
        #20000;
        error_cnt++;
        print_verdict();
    end
    // main sequence
    initial begin
        {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = '0;
        pstrb_in = 4'hf;
        periph_drive_in = 16'h0000;
        periph_data_in = 16'h0000;
        ext_level = 16'hc3c3;
        arst_n_in = 1'b0;
        repeat (4) @(posedge clk_in);
        arst_n_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        chk({16'h0, pad_oe_n_out}, 32'h0000_ffff);
        rchk(`DIR_OFFSET, 32'h0000_7fff);
        chk({31'h0, err}, 32'h0);
        rchk(`LAT_OFFSET, 32'h0000_0000);
        xfer(1'b1, `LAT_OFFSET, 32'h1234_a5a5);
        rchk(`LAT_OFFSET, 32'h0000_25a5);
        xfer(1'b1, `DIR_OFFSET, 32'h0000_0000);
        chk({16'h0, pad_oe_n_out}, 32'h0000_8000);
        chk({16'h0, pad_out & 16'h7fff}, 32'h0000_25a5);
        xfer(1'b1, `PIN_OFFSET, 32'h0000_0f0f);
        rchk(`LAT_OFFSET, 32'h0000_0f0f);
        rchk(`PIN_OFFSET, 32'h0000_0f0f);
        xfer(1'b1, `DIR_OFFSET, 32'h0000_ff00);
        rchk(`PIN_OFFSET, 32'h0000_430f);
        xfer(1'b1, `ANA_OFFSET, 32'h0000_000f);
        rchk(`PIN_OFFSET, 32'h0000_4300);
        xfer(1'b1, `DIR_OFFSET, 32'h0000_0000);
        periph_drive_in <= 16'h00f1;
        periph_data_in <= 16'h00a0;
        // pads are compared mid-cycle, where the new ownership has settled
        @(negedge clk_in);
        chk({16'h0, pad_oe_n_out}, 32'h0000_8000);
        chk({16'h0, pad_out & 16'h7fff}, 32'h0000_0faf);
        @(posedge clk_in);
        xfer(1'b1, `DIR_OFFSET, 32'h0000_ffff);
        chk({16'h0, pad_oe_n_out}, 32'h0000_ff0f);
        rchk(`PIN_OFFSET, 32'h0000_43a0);
        xfer(1'b1, `DIR_OFFSET, 32'h0000_0000);
        periph_drive_in <= 16'h0000;
        @(negedge clk_in);
        chk({16'h0, pad_out & 16'h7fff}, 32'h0000_0f0f);
        @(posedge clk_in);
        // low byte lane only: the upper latch bits keep their value
        pstrb_in <= 4'h1;
        xfer(1'b1, `LAT_OFFSET, 32'h0000_a55a);
        pstrb_in <= 4'hf;
        rchk(`LAT_OFFSET, 32'h0000_0f5a);
        xfer(1'b1, 12'h010, 32'h0000_ffff);
        chk({31'h0, err}, 32'h1);
        rchk(12'h010, 32'h0000_0000);
        chk({31'h0, err}, 32'h1);
        rchk(`LAT_OFFSET, 32'h0000_0f5a);
        rchk(`ANA_OFFSET, 32'h0000_000f);
        chk({31'h0, err}, 32'h0);
        rchk(`DIR_OFFSET, 32'h0000_0000);
        // second reset in mid-run: every pin back to input, latch cleared
        arst_n_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        arst_n_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        chk({16'h0, pad_oe_n_out}, 32'h0000_ffff);
        rchk(`DIR_OFFSET, 32'h0000_7fff);
        rchk(`LAT_OFFSET, 32'h0000_0000);
        print_verdict();
    end
endmodule
